// ===== rtl/fslr_defines.svh
// Purpose: Named offsets, field positions and timing counts of the self-programming block.
// Assumes: Included by bare name from every design file.
// Notes: Only definitions live here.
`ifndef FSLR_DEFINES_SVH
`define FSLR_DEFINES_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define FSLR_OFS_CTRL 8'h00
`define FSLR_OFS_ZPTR 8'h04
`define FSLR_OFS_LOAD 8'h08
`define FSLR_OFS_STORE 8'h0C
`define FSLR_OFS_STATUS 8'h10

// ----------------------------------------
// Control register bit positions and command values
// ----------------------------------------
`define FSLR_B_STORE_PROGRAM_ENABLE 0
`define FSLR_B_PGERS 1
`define FSLR_B_PGWRT 2
`define FSLR_B_ARM 3
`define FSLR_B_REEN 4
`define FSLR_B_RWWB 6
`define FSLR_CMD_LO 5
`define FSLR_CMD_LOCKWR 6'h09
`define FSLR_CMD_ERASE 6'h03
`define FSLR_CMD_WRITE 6'h05

// ----------------------------------------
// Readback pointers and windows
// ----------------------------------------
`define FSLR_Z_FUSE_LO 16'h0000
`define FSLR_Z_LOCK 16'h0001
`define FSLR_Z_FUSE_HI 16'h0003
`define FSLR_LOAD_WIN 3'h3
`define FSLR_STORE_LAST 3'h3
`define FSLR_UNMAPPED_BYTE 8'hFF
`define FSLR_LOCK_UNUSED 2'h3
`define FSLR_LOCK_W 6
`define FSLR_LOCKWR_HI 5
`define FSLR_LOCKWR_LO 2

// ----------------------------------------
// Flash geometry and boot size
// ----------------------------------------
`define FSLR_PC_W 12
`define FSLR_PAGE_W 7
`define FSLR_WORD_W 5
`define FSLR_Z_PAGE_HI 12
`define FSLR_Z_PAGE_LO 6
`define FSLR_Z_WORD_HI 5
`define FSLR_Z_WORD_LO 1
`define FSLR_NO_READ_WHILE_WRITE_REGION_FIRST_PAGE 7'h60
`define FSLR_BOOT_128 12'hF80
`define FSLR_BOOT_256 12'hF00
`define FSLR_BOOT_512 12'hE00
`define FSLR_BOOT_1024 12'hC00
`define FSLR_BOOTSZ_HI 2
`define FSLR_BOOTSZ_LO 1

// ----------------------------------------
// Programming time and bus response codes
// ----------------------------------------
`define FSLR_CLK_MHZ 250
`define FSLR_PROG_MIN_US 3700
`define FSLR_PROG_MAX_US 4500
`define FSLR_PROG_NOM_US 4000
`define FSLR_PROG_CYCLES (`FSLR_PROG_NOM_US * `FSLR_CLK_MHZ)
`define FSLR_PROG_MIN_CYC (`FSLR_PROG_MIN_US * `FSLR_CLK_MHZ)
`define FSLR_PROG_MAX_CYC (`FSLR_PROG_MAX_US * `FSLR_CLK_MHZ)
`define FSLR_PROG_CW 21
`define FSLR_RESP_OKAY 2'h0
`define FSLR_RESP_SLVERR 2'h2

`endif

// ===== rtl/fslr_pkg.sv
// Purpose: Types shared by the self-programming block.
// Assumes: fslr_defines.svh gives the widths.
// Notes: State structs hold every flip-flop of a module except the page buffer of the top.
`include "fslr_defines.svh"

package fslr_pkg;

	// Timed flash operation kinds.
	typedef enum logic [1:0] {FSLR_OP_ERASE = 2'h0, FSLR_OP_WRITE = 2'h1, FSLR_OP_LOCK = 2'h2} fslr_op_t;

	// Operation timer states, Gray coded along idle, run, done.
	typedef enum logic [1:0] {FSLR_T_IDLE = 2'h0, FSLR_T_RUN = 2'h1, FSLR_T_DONE = 2'h3} fslr_tstate_t;

	typedef struct packed {
		fslr_tstate_t st;
		logic [`FSLR_PROG_CW-1:0] cnt;
		fslr_op_t kind;
		logic [`FSLR_PAGE_W-1:0] page;
		logic [3:0] mask;
	} fslr_tmr_t;

	typedef struct packed {
		logic spm_en;
		logic pg_erase;
		logic pg_write;
		logic lock_arm;
		logic rww_busy;
		logic [2:0] win;
		logic [15:0] zptr;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [15:0] buf_rd_data;
	} fslr_state_t;

endpackage

// ===== rtl/fslr_op_timer.sv
// Purpose: Times one page erase, page write or lock write and holds its latched address.
// Assumes: Timebase is the calibrated clock; start only while idle.
// Notes: A reset during a run does not stop the run.
`timescale 1ns/100ps
`default_nettype none
`include "fslr_defines.svh"

module fslr_op_timer
	import fslr_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = `FSLR_PROG_CYCLES
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic start,
	input wire fslr_op_t start_kind,
	input wire logic [`FSLR_PAGE_W-1:0] start_page,
	input wire logic [3:0] start_mask,
	output logic busy,
	output logic done,
	output fslr_op_t kind,
	output logic [`FSLR_PAGE_W-1:0] page,
	output logic [3:0] mask
);

	localparam logic [`FSLR_PROG_CW-1:0] LAST = `FSLR_PROG_CW'(PROG_CYCLES - 1);

	fslr_tmr_t cs;
	fslr_tmr_t next_cs;

	// Next state: latch the operation, count it out, then pulse done once.
	always_comb
	begin
		next_cs = cs;
		case (cs.st)
			FSLR_T_IDLE:
			begin
				if (start)
				begin
					next_cs.st = FSLR_T_RUN;
					next_cs.cnt = '0;
					next_cs.kind = start_kind;
					next_cs.page = start_page;
					next_cs.mask = start_mask;
				end
			end
			FSLR_T_RUN:
			begin
				if (cs.cnt == LAST)
					next_cs.st = FSLR_T_DONE;
				else
					next_cs.cnt = cs.cnt + 1'b1;
			end
			FSLR_T_DONE:
				next_cs.st = FSLR_T_IDLE;
			default:
				next_cs.st = FSLR_T_IDLE;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn && cs.st != FSLR_T_RUN)
			cs <= '{st: FSLR_T_IDLE, cnt: '0, kind: FSLR_OP_ERASE, page: '0, mask: '0};
		else
			cs <= next_cs;
	end

	assign busy = (cs.st == FSLR_T_RUN);
	assign done = (cs.st == FSLR_T_DONE);
	assign kind = cs.kind;
	assign page = cs.page;
	assign mask = cs.mask;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_prog_time;
		@(posedge aclk) disable iff (!aresetn)
		(busy && cs.cnt != LAST) |=> busy && (cs.cnt == $past(cs.cnt) + 1'b1);
	endproperty
	a_prog_time: assert property (p_prog_time) else $error("operation count skipped a cycle");

	property p_reset_keeps_run;
		@(posedge aclk)
		(!aresetn && cs.st == FSLR_T_RUN && cs.cnt != LAST) |=> (cs.st == FSLR_T_RUN && cs.kind == $past(cs.kind));
	endproperty
	a_reset_keeps_run: assert property (p_reset_keeps_run) else $error("reset stopped a write");

endmodule
`default_nettype wire

// ===== rtl/fslr_top.sv
// Purpose: Self-programming control, fuse and lock readback, pointer split and boot size decode.
// Assumes: AXI4-Lite master is the CPU core; one clock cycle equals one CPU cycle.
// Notes: Load and store are register accesses at their own offsets.
`timescale 1ns/100ps
`default_nettype none
`include "fslr_defines.svh"

module fslr_top
	import fslr_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = `FSLR_PROG_CYCLES,
	parameter int unsigned ADDR_W = 8
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [`FSLR_LOCK_W-1:0] lock_programmed,
	input wire logic [7:0] fuse_low_programmed,
	input wire logic [7:0] fuse_high_programmed,
	output logic [`FSLR_PC_W-1:0] flash_rd_addr,
	input wire logic [15:0] flash_rd_data,
	output logic prog_active,
	output logic [1:0] prog_kind,
	output logic [`FSLR_PAGE_W-1:0] prog_page,
	output logic [3:0] prog_lock_mask,
	input wire logic [`FSLR_WORD_W-1:0] buf_rd_idx,
	output logic [15:0] buf_rd_data,
	output logic [`FSLR_PC_W-1:0] boot_start_addr,
	output logic rww_busy_flag
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------

	// region split is fixed, not tied to boot size.
	function automatic logic is_rww_page(input logic [`FSLR_PAGE_W-1:0] pg);
		is_rww_page = (pg < `FSLR_NO_READ_WHILE_WRITE_REGION_FIRST_PAGE);
	endfunction

	fslr_state_t cs;
	fslr_state_t next_cs;
	logic [15:0] page_buf [0:(1<<`FSLR_WORD_W)-1];
	logic wr_hit;
	logic rd_hit;
	logic load_hit;
	logic store_hit;
	logic ctrl_wr;
	logic armed;
	logic load_ok;
	logic [7:0] flash_byte;
	logic [7:0] cfg_byte;
	logic buf_we;
	logic buf_clear;
	logic op_start;
	fslr_op_t op_kind;
	logic [3:0] op_mask;
	logic tmr_busy;
	logic tmr_done;
	fslr_op_t tmr_kind;
	logic [`FSLR_PAGE_W-1:0] z_page;
	logic [`FSLR_WORD_W-1:0] z_word;
	logic [`FSLR_BOOTSZ_HI:`FSLR_BOOTSZ_LO] boot_sel;

	// ----------------------------------------
	// Decode
	// ----------------------------------------

	// Bus handshakes: one write and one read outstanding at most.
	assign wr_hit = awvalid && wvalid && !cs.bvalid;
	assign rd_hit = arvalid && !cs.rvalid;
	assign awready = wr_hit;
	assign wready = wr_hit;
	assign arready = !cs.rvalid;
	assign load_hit = rd_hit && (araddr == ADDR_W'(`FSLR_OFS_LOAD));
	assign store_hit = wr_hit && wstrb[0] && (awaddr == ADDR_W'(`FSLR_OFS_STORE));
	assign ctrl_wr = wr_hit && wstrb[0] && (awaddr == ADDR_W'(`FSLR_OFS_CTRL));
	// readback needs both arm bits and a load in the window.
	assign armed = cs.lock_arm && cs.spm_en;
	assign load_ok = armed && (cs.win < `FSLR_LOAD_WIN);

	assign z_page = cs.zptr[`FSLR_Z_PAGE_HI:`FSLR_Z_PAGE_LO];
	assign z_word = cs.zptr[`FSLR_Z_WORD_HI:`FSLR_Z_WORD_LO];
	// word address drops Z0 and the ignored top bits.
	assign flash_rd_addr = cs.zptr[`FSLR_PC_W:1];
	// Z0 picks the byte of the flash word.
	assign flash_byte = cs.zptr[0] ? flash_rd_data[15:8] : flash_rd_data[7:0];

	// Configuration byte for the current pointer; fuse cells flag programmed as one.
	always_comb
	begin
		cfg_byte = `FSLR_UNMAPPED_BYTE;
		// Z15:Z13 never take part in the match.
		case ({3'b000, cs.zptr[`FSLR_Z_PAGE_HI:0]})
			// unused, boot, app, memory lock pairs.
			// inversion makes programmed bits read zero.
			`FSLR_Z_LOCK:
				cfg_byte = {`FSLR_LOCK_UNUSED, ~lock_programmed};
			// low fuse byte, bit for bit.
			`FSLR_Z_FUSE_LO:
				cfg_byte = ~fuse_low_programmed;
			// high fuse byte, bit for bit.
			`FSLR_Z_FUSE_HI:
				cfg_byte = ~fuse_high_programmed;
			// other pointers give a fixed byte.
			default:
				cfg_byte = `FSLR_UNMAPPED_BYTE;
		endcase
	end

	// boot size fuses choose the boot start, read as unprogrammed ones.
	assign boot_sel = ~fuse_high_programmed[`FSLR_BOOTSZ_HI:`FSLR_BOOTSZ_LO];
	always_comb
	begin
		case (boot_sel)
			2'h3: boot_start_addr = `FSLR_BOOT_128;
			2'h2: boot_start_addr = `FSLR_BOOT_256;
			2'h1: boot_start_addr = `FSLR_BOOT_512;
			default: boot_start_addr = `FSLR_BOOT_1024;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------

	// All software effects of the bus land here; later assignments take priority.
	always_comb
	begin
		next_cs = cs;
		buf_we = 1'b0;
		buf_clear = 1'b0;
		op_start = 1'b0;
		op_kind = FSLR_OP_ERASE;
		op_mask = 4'h0;
		if (cs.bvalid && bready)
			next_cs.bvalid = 1'b0;
		if (cs.rvalid && rready)
			next_cs.rvalid = 1'b0;
		next_cs.buf_rd_data = page_buf[buf_rd_idx];
		// no store inside four cycles disarms everything.
		if (cs.spm_en)
		begin
			if (cs.win == `FSLR_STORE_LAST)
			begin
				next_cs.spm_en = 1'b0;
				next_cs.pg_erase = 1'b0;
				next_cs.pg_write = 1'b0;
				next_cs.lock_arm = 1'b0;
			end
			else
				next_cs.win = cs.win + 3'h1;
		end
		if (wr_hit)
		begin
			next_cs.bvalid = 1'b1;
			next_cs.bresp = `FSLR_RESP_OKAY;
			case (awaddr)
				ADDR_W'(`FSLR_OFS_CTRL):
				begin
					// Writes during a timed operation are ignored, as the flash is busy.
					if (wstrb[0] && !tmr_busy)
					begin
						next_cs.spm_en = wdata[`FSLR_B_STORE_PROGRAM_ENABLE];
						next_cs.pg_erase = wdata[`FSLR_B_PGERS];
						next_cs.pg_write = wdata[`FSLR_B_PGWRT];
						next_cs.lock_arm = wdata[`FSLR_B_ARM];
						// a fresh arming restarts the window.
						next_cs.win = 3'h0;
						// only the re-enable command clears the busy flag.
						if (wdata[`FSLR_B_REEN] && wdata[`FSLR_B_STORE_PROGRAM_ENABLE])
						begin
							next_cs.rww_busy = 1'b0;
							next_cs.spm_en = 1'b0;
							buf_clear = 1'b1;
						end
					end
				end
				ADDR_W'(`FSLR_OFS_ZPTR):
				begin
					if (wstrb[0])
						next_cs.zptr[7:0] = wdata[7:0];
					if (wstrb[1])
						next_cs.zptr[15:8] = wdata[15:8];
				end
				ADDR_W'(`FSLR_OFS_STORE):
				begin
					if (store_hit && cs.spm_en && !tmr_busy)
					begin
						next_cs.spm_en = 1'b0;
						next_cs.pg_erase = 1'b0;
						next_cs.pg_write = 1'b0;
						next_cs.lock_arm = 1'b0;
						// cleared source bits 5..2 program the boot locks.
						if ({cs.pg_write, cs.pg_erase, cs.lock_arm} == 3'b001)
						begin
							op_start = 1'b1;
							op_kind = FSLR_OP_LOCK;
							op_mask = ~wdata[`FSLR_LOCKWR_HI:`FSLR_LOCKWR_LO];
						end
						else if (cs.pg_erase)
						begin
							op_start = 1'b1;
							op_kind = FSLR_OP_ERASE;
						end
						else if (cs.pg_write)
						begin
							op_start = 1'b1;
							op_kind = FSLR_OP_WRITE;
						end
						else
							buf_we = 1'b1;
					end
				end
				ADDR_W'(`FSLR_OFS_LOAD), ADDR_W'(`FSLR_OFS_STATUS):
					next_cs.bresp = `FSLR_RESP_OKAY;
				default:
					next_cs.bresp = `FSLR_RESP_SLVERR;
			endcase
		end
		if (rd_hit)
		begin
			next_cs.rvalid = 1'b1;
			next_cs.rresp = `FSLR_RESP_OKAY;
			next_cs.rdata = 32'h0000_0000;
			case (araddr)
				ADDR_W'(`FSLR_OFS_CTRL):
					next_cs.rdata[7:0] = {1'b0, cs.rww_busy, 2'h0, cs.lock_arm, cs.pg_write, cs.pg_erase,
						cs.spm_en | tmr_busy};
				ADDR_W'(`FSLR_OFS_ZPTR):
					next_cs.rdata[15:0] = cs.zptr;
				ADDR_W'(`FSLR_OFS_LOAD):
				begin
					// outside the armed window the load reads flash.
					if (load_ok)
					begin
						next_cs.rdata[7:0] = cfg_byte;
						next_cs.spm_en = 1'b0;
						next_cs.lock_arm = 1'b0;
					end
					else
						next_cs.rdata[7:0] = flash_byte;
				end
				ADDR_W'(`FSLR_OFS_STATUS):
					next_cs.rdata = {4'h0, boot_start_addr, 15'h0000, tmr_busy};
				default:
					next_cs.rresp = `FSLR_RESP_SLVERR;
			endcase
		end
		// a start in the re-enable cycle keeps the flag set.
		if (op_start && op_kind != FSLR_OP_LOCK && is_rww_page(z_page))
			next_cs.rww_busy = 1'b1;
	end

	// ----------------------------------------
	// State and page buffer
	// ----------------------------------------

	// Single registered copy of the state.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cs <= '0;
		else
			cs <= next_cs;
	end

	// Page buffer clears on reset, re-enable and after a page write.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || buf_clear || (tmr_done && tmr_kind == FSLR_OP_WRITE))
		begin
			for (int i = 0; i < (1<<`FSLR_WORD_W); i++)
				page_buf[i] <= 16'h0000;
		end
		else if (buf_we)
			page_buf[z_word] <= wdata[15:0];
	end

	// every timed operation runs for the nominal programming time.
	fslr_op_timer #(
		.PROG_CYCLES(PROG_CYCLES)
	) u_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(op_start),
		.start_kind(op_kind),
		.start_page(z_page),
		.start_mask(op_mask),
		.busy(tmr_busy),
		.done(tmr_done),
		.kind(tmr_kind),
		.page(prog_page),
		.mask(prog_lock_mask)
	);

	assign prog_active = tmr_busy;
	assign prog_kind = tmr_kind;
	assign buf_rd_data = cs.buf_rd_data;
	assign rww_busy_flag = cs.rww_busy;
	assign bvalid = cs.bvalid;
	assign bresp = cs.bresp;
	assign rvalid = cs.rvalid;
	assign rresp = cs.rresp;
	assign rdata = cs.rdata;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_armed_load(logic [15:0] z);
		load_hit && load_ok && {3'b000, cs.zptr[`FSLR_Z_PAGE_HI:0]} == z;
	endsequence

	property p_lock_read;
		s_armed_load(`FSLR_Z_LOCK) |=> rdata[7:0] == {2'b11, ~$past(lock_programmed)} && !armed;
	endproperty
	a_lock_read: assert property (p_lock_read) else $error("lock byte readback wrong");

	property p_fuse_low;
		s_armed_load(`FSLR_Z_FUSE_LO) |=> rdata[7:0] == ~$past(fuse_low_programmed);
	endproperty
	a_fuse_low: assert property (p_fuse_low) else $error("low fuse readback wrong");

	property p_fuse_high;
		s_armed_load(`FSLR_Z_FUSE_HI) |=> rdata[7:0] == ~$past(fuse_high_programmed);
	endproperty
	a_fuse_high: assert property (p_fuse_high) else $error("high fuse readback wrong");

	property p_plain_load;
		(load_hit && !armed) |=> rdata[7:0] == $past(flash_byte);
	endproperty
	a_plain_load: assert property (p_plain_load) else $error("disarmed load not a flash read");

	property p_window_expiry;
		(cs.spm_en && cs.win == `FSLR_STORE_LAST && !wr_hit) |=> !cs.spm_en && !cs.lock_arm;
	endproperty
	a_window_expiry: assert property (p_window_expiry) else $error("arm bits outlived window");

	property p_window_restart;
		(ctrl_wr && !tmr_busy && wdata[`FSLR_B_STORE_PROGRAM_ENABLE] && !wdata[`FSLR_B_REEN]) |=> cs.win == 3'h0 ##1 cs.win == 3'h1;
	endproperty
	a_window_restart: assert property (p_window_restart) else $error("window not restarted");

	property p_busy_hold;
		(cs.rww_busy && !(ctrl_wr && wdata[`FSLR_B_REEN])) |=> cs.rww_busy;
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy flag dropped early");

	property p_page_latch;
		(op_start && op_kind == FSLR_OP_ERASE) |=> prog_active && prog_page == $past(cs.zptr[`FSLR_Z_PAGE_HI:`FSLR_Z_PAGE_LO]);
	endproperty
	a_page_latch: assert property (p_page_latch) else $error("erase page not from Z12:Z6");

endmodule
`default_nettype wire

// ===== test/fslr_flash_model.sv
// Purpose: Program flash array behind the ordinary load path.
// Assumes: Each word is a fixed function of its word address.
// Notes: The array always drives its data, so nothing is released.
`timescale 1ns/100ps
`default_nettype none
`include "fslr_defines.svh"

module fslr_flash_model
(
	input wire logic [`FSLR_PC_W-1:0] rd_addr,
	output logic [15:0] rd_data
);
	// ----------------------------------------
	// Array content
	// ----------------------------------------
	// ordinary flash word
	// The marker nibble makes the two byte lanes differ, so a wrong byte select shows.
	assign rd_data = {4'hA, rd_addr};
endmodule

`default_nettype wire

// ===== test/flash_selfprog_fuse_lock_readback_tb.sv
// Purpose: Self-checking bench for the self-programming block.
// Assumes: Handshake ready inputs stay high; the timed run is shortened.
// Notes: Each scenario drives the bus and judges the answers itself.
`timescale 1ns/100ps
`default_nettype none
`include "fslr_defines.svh"

module flash_selfprog_fuse_lock_readback_tb
	import fslr_pkg::*;
;
	localparam int PC = 20;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic [5:0] lock_p = 6'h25;
	logic [7:0] fuse_lo = 8'h3C;
	logic [7:0] fuse_hi = 8'h81;
	logic [4:0] buf_idx = 5'h00;
	logic [31:0] rdata;
	logic [1:0] bresp, rresp, prog_kind;
	logic awready, wready, bvalid, arready, rvalid, prog_active, rww_busy;
	logic [11:0] fl_addr, boot_start;
	logic [15:0] fl_data, buf_data;
	logic [6:0] prog_page;
	logic [3:0] prog_mask;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	int run_cur = 0;
	int run_last = 0;

	// ----------------------------------------
	// Design, flash array and clock
	// ----------------------------------------
	fslr_top #(.PROG_CYCLES(PC)) dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1),
		.lock_programmed(lock_p), .fuse_low_programmed(fuse_lo), .fuse_high_programmed(fuse_hi),
		.flash_rd_addr(fl_addr), .flash_rd_data(fl_data), .prog_active(prog_active), .prog_kind(prog_kind),
		.prog_page(prog_page), .prog_lock_mask(prog_mask), .buf_rd_idx(buf_idx), .buf_rd_data(buf_data),
		.boot_start_addr(boot_start), .rww_busy_flag(rww_busy));
	fslr_flash_model flash_u (.rd_addr(fl_addr), .rd_data(fl_data));

	// Half period of 2 ns gives 250 MHz.
	always #2 aclk = ~aclk;

	// Cycle ceiling; the whole sequence needs well under a thousand cycles.
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			close_out();
		end
	end

	// Measures every timed run in whole cycles, so the first cycle is not lost to the bus answer.
	always @(posedge aclk)
	begin
		if (prog_active === 1'b1)
			run_cur <= run_cur + 1;
		else if (run_cur != 0)
		begin
			run_last <= run_cur;
			run_cur <= 0;
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask

	// Ready inputs stay high, so each channel ends at its answer edge.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		@(posedge aclk);
		while (awready !== 1'b1)
			@(posedge aclk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		@(posedge aclk);
		while (bvalid !== 1'b1)
			@(posedge aclk);
		r = bresp;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		@(posedge aclk);
		while (arready !== 1'b1)
			@(posedge aclk);
		arvalid <= 1'b0;
		@(posedge aclk);
		while (rvalid !== 1'b1)
			@(posedge aclk);
		d = rdata;
		r = rresp;
	endtask

	// Waits for the running operation to end and returns its measured length.
	task automatic run_len(output int n);
		@(negedge aclk);
		while (prog_active === 1'b1)
			@(negedge aclk);
		repeat (2) @(posedge aclk);
		n = run_last;
	endtask

	// Ordinary load: word address from pointer bits 12..1, bit 0 picks the byte.
	function automatic logic [7:0] plain(input logic [15:0] z);
		return z[0] ? {4'hA, z[12:9]} : z[8:1];
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_readback();
		logic [15:0] z[4] = '{16'h0000, 16'h0001, 16'h0003, 16'h0002};
		logic [7:0] e[4];
		logic [31:0] d;
		logic [1:0] r;
		e = '{~fuse_lo, {2'b11, ~lock_p}, ~fuse_hi, 8'hFF};
		foreach (z[i])
		begin
			wr(`FSLR_OFS_ZPTR, {16'h0, z[i]}, r);
			wr(`FSLR_OFS_CTRL, 32'h9, r);
			rd(`FSLR_OFS_LOAD, d, r);
			chk("armed load", {24'h0, e[i]}, d & 32'hFF);
			rd(`FSLR_OFS_CTRL, d, r);
			chk("arm cleared", 32'h0, d & 32'h9);
			rd(`FSLR_OFS_LOAD, d, r);
			chk("plain load", {24'h0, plain(z[i])}, d & 32'hFF);
		end
	endtask

	task automatic t_expire();
		logic [31:0] d;
		logic [1:0] r;
		wr(`FSLR_OFS_ZPTR, 32'hE001, r);
		wr(`FSLR_OFS_CTRL, 32'h9, r);
		repeat (6) @(posedge aclk);
		rd(`FSLR_OFS_CTRL, d, r);
		chk("arm timeout", 32'h0, d & 32'h9);
		rd(`FSLR_OFS_LOAD, d, r);
		chk("late load", 32'hA0, d & 32'hFF);
		wr(`FSLR_OFS_CTRL, 32'h9, r);
		@(posedge aclk);
		wr(`FSLR_OFS_CTRL, 32'h9, r);
		rd(`FSLR_OFS_LOAD, d, r);
		chk("rearmed load", {26'h3, ~lock_p}, d & 32'hFF);
	endtask

	task automatic t_boot();
		logic [11:0] e[4] = '{12'hC00, 12'hE00, 12'hF00, 12'hF80};
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 4; i++)
		begin
			fuse_hi <= {5'h0, ~i[1:0], 1'b0};
			rd(`FSLR_OFS_STATUS, d, r);
			chk("boot status", {20'h0, e[i]}, {20'h0, d[27:16]});
			chk("boot port", {20'h0, e[i]}, {20'h0, boot_start});
		end
	endtask

	task automatic t_fill();
		logic [1:0] r;
		wr(`FSLR_OFS_ZPTR, 32'h000E, r);
		wr(`FSLR_OFS_CTRL, 32'h1, r);
		wr(`FSLR_OFS_STORE, 32'hBEEF, r);
		buf_idx <= 5'h07;
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		chk("buffer word", 32'hBEEF, {16'h0, buf_data});
		@(posedge aclk);
	endtask

	task automatic t_rww();
		int n;
		logic [1:0] r;
		wr(`FSLR_OFS_ZPTR, 32'hE140, r);
		wr(`FSLR_OFS_CTRL, 32'h3, r);
		wr(`FSLR_OFS_STORE, 32'h0, r);
		run_len(n);
		chk("erase length", PC, n);
		chk("erase page", 32'h5, {25'h0, prog_page});
		chk("erase kind", 32'h0, {30'h0, prog_kind});
		chk("busy held", 32'h1, {31'h0, rww_busy});
		wr(`FSLR_OFS_CTRL, 32'h11, r);
		@(negedge aclk);
		chk("busy cleared", 32'h0, {31'h0, rww_busy});
		@(posedge aclk);
		wr(`FSLR_OFS_ZPTR, 32'h1800, r);
		wr(`FSLR_OFS_CTRL, 32'h5, r);
		wr(`FSLR_OFS_STORE, 32'h0, r);
		run_len(n);
		chk("write length", PC, n);
		chk("write page", 32'h60, {25'h0, prog_page});
		chk("write kind", 32'h1, {30'h0, prog_kind});
		chk("no busy", 32'h0, {31'h0, rww_busy});
	endtask

	task automatic t_lock_reset();
		int n;
		logic [1:0] r;
		wr(`FSLR_OFS_ZPTR, 32'h1, r);
		wr(`FSLR_OFS_CTRL, 32'h9, r);
		wr(`FSLR_OFS_STORE, 32'hD7, r);
		@(negedge aclk);
		chk("lock kind", 32'h2, {30'h0, prog_kind});
		chk("lock mask", 32'hA, {28'h0, prog_mask});
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk("run survives", 32'h1, {31'h0, prog_active});
		run_len(n);
		chk("run ends", PC, n);
	endtask

	task automatic t_unmapped();
		logic [31:0] d;
		logic [1:0] r;
		wr(8'h20, 32'hFFFF, r);
		chk("write resp", `FSLR_RESP_SLVERR, {30'h0, r});
		rd(8'h20, d, r);
		chk("read resp", `FSLR_RESP_SLVERR, {30'h0, r});
	endtask

	task automatic close_out();
		$display("mismatches %0d checks %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	// Reset is held ten cycles before the first request.
	initial
	begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_readback();
		t_expire();
		t_boot();
		t_fill();
		t_rww();
		t_lock_reset();
		t_unmapped();
		close_out();
	end
endmodule

`default_nettype wire
